// [verilog/can_mode_pkg.sv]
package can_mode_pkg;

   // ****************************************
   // register map (byte addresses, our choice)
   // ****************************************
   localparam logic [7:0] ADDR_CTL0    = 8'h00;
   localparam logic [7:0] ADDR_CTL1    = 8'h04;
   localparam logic [7:0] ADDR_MISC    = 8'h08;
   localparam logic [7:0] ADDR_TXERR   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_TBSEL   = 8'h14;
   localparam logic [7:0] ADDR_BUFRD   = 8'h18;
   localparam logic [7:0] ADDR_TSTAMP  = 8'h1C;

   // ****************************************
   // control register zero fields
   // ****************************************
   localparam int BIT_RECEIVED_FRAME_FLAG  = 7;
   localparam int BIT_RECEIVER_ACTIVE  = 6;
   localparam int BIT_STOP_IN_WAIT  = 5;
   localparam int BIT_SYNC   = 4;
   localparam int BIT_TIME   = 3;
   localparam int BIT_WAKEUP_ENABLE   = 2;
   localparam int BIT_SLEEP_REQUEST  = 1;
   localparam int BIT_INIT_REQUEST = 0;

   // control register one fields
   localparam int BIT_MODULE_ENABLE   = 7;
   localparam int BIT_BUSOFF_RECOVERY_MODE   = 3;
   localparam int BIT_SLEEP_ACKNOWLEDGE  = 1;
   localparam int BIT_INIT_ACKNOWLEDGE = 0;

   // miscellaneous register field
   localparam int BIT_BUSOFF_HOLD = 0;

   // status register fields
   localparam int BIT_BUSOFF = 0;
   localparam int BIT_SLEEP  = 1;

   localparam logic [7:0] CTL0_RESET = 8'h01;
   localparam logic [7:0] CTL1_RESET = 8'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // bus-off recovery figures
   // ****************************************
   localparam int RECESSIVE_RUN  = 11;
   localparam int RECOVERY_RUNS  = 128;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic       rx_valid_frame;
      logic       receiving;
      logic       transmitting;
      logic       synchronized;
      logic       eof_pulse;
      logic       frame_was_rx;
      logic       bus_traffic;
      logic       bus_idle;
      logic       recessive_bit;
      logic       bit_tick;
      logic       loopback;
      logic       busoff_enter;
   } link_status_t;

   typedef struct packed {
      logic        we;
      logic [3:0]  addr;
      logic [15:0] data;
   } stamp_write_t;

endpackage

// [verilog/bit_timer.sv]
`timescale 1ns/1ns
module bit_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             enable,
   input  wire logic             tick,
   output logic      [WIDTH-1:0] count
);
   // free running while enabled, cleared whenever disabled
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !enable) begin
         count <= '0;
      end else if (tick) begin
         count <= count + 1'b1;
      end
   end
endmodule

// [verilog/recessive_counter.sv]
`timescale 1ns/1ns
module recessive_counter #(
   parameter int RUN  = 11,
   parameter int RUNS = 128
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic active,
   input  wire logic tick,
   input  wire logic recessive,
   output logic      done
);
   logic [7:0] bit_reg;
   logic [8:0] run_reg;

   // counts runs of consecutive recessive bits while armed
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !active) begin
         bit_reg <= '0;
         run_reg <= '0;
      end else if (tick && !done) begin
         if (!recessive) begin
            bit_reg <= '0;
         end else if (bit_reg == 8'(RUN - 1)) begin
            bit_reg <= '0;
            run_reg <= run_reg + 1'b1;
         end else begin
            bit_reg <= bit_reg + 1'b1;
         end
      end
   end

   assign done = (run_reg == 9'(RUNS));
endmodule

// [verilog/can_mode_control.sv]
`timescale 1ns/1ns
module can_mode_control #(
   parameter int TIMER_WIDTH = 16,
   parameter int TX_BUFFERS  = 3
) (
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   // axi4-lite slave
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic      [1:0]               s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic      [31:0]              s_axi_rdata,
   output logic      [1:0]               s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // protocol core side
   input  can_mode_pkg::link_status_t    link,
   input  wire logic [7:0]               tx_error_count,
   input  wire logic [TX_BUFFERS-1:0]    tx_buffer_empty_flag,
   input  wire logic                     rx_buffer_full_flag,
   input  wire logic [31:0]              buffer_read_data,
   input  wire logic                     wait_mode,
   output logic                          bus_clock_enable,
   output logic                          busoff_recover,
   output logic                          wakeup,
   output can_mode_pkg::stamp_write_t    stamp_write
);

   // ****************************************
   // registers
   // ****************************************
   logic [7:0]             ctl0_reg;
   logic                   module_enable_reg;
   logic                   busoff_recovery_mode_reg;
   logic                   busoff_hold_reg;
   logic                   init_acknowledge_reg;
   logic                   sleep_acknowledge_reg;
   logic                   sleep_wakeup_enable_reg;
   logic                   busoff_reg;
   logic [TX_BUFFERS-1:0]  tx_buffer_select_reg;
   logic [TIMER_WIDTH-1:0] timer_count;
   logic                   runs_done;
   logic                   init_mode;
   logic                   sleep_mode;

   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_fire;
   logic        wr_ok;
   logic        rd_ok;
   logic [31:0] rd_value;

   assign init_mode  = ctl0_reg[can_mode_pkg::BIT_INIT_REQUEST] && init_acknowledge_reg;
   assign sleep_mode = ctl0_reg[can_mode_pkg::BIT_SLEEP_REQUEST] && sleep_acknowledge_reg;

   // ****************************************
   // axi4-lite write path
   // ****************************************
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   always_comb begin
      unique case (aw_addr_reg)
         can_mode_pkg::ADDR_CTL0,
         can_mode_pkg::ADDR_CTL1,
         can_mode_pkg::ADDR_MISC,
         can_mode_pkg::ADDR_TBSEL: wr_ok = 1'b1;
         // read-only registers: write unimplemented
         default:                  wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= can_mode_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? can_mode_pkg::RESP_OKAY : can_mode_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_byte0;
   assign wr_byte0 = wr_fire && w_strb_reg[0];

   // ****************************************
   // control register zero
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctl0_reg <= can_mode_pkg::CTL0_RESET;
      end else begin
         // received frame flag: set beats a clearing write
         if (link.rx_valid_frame) begin
            ctl0_reg[can_mode_pkg::BIT_RECEIVED_FRAME_FLAG] <= 1'b1;
         end else if (init_mode) begin
            ctl0_reg[can_mode_pkg::BIT_RECEIVED_FRAME_FLAG] <= 1'b0;
         end else if (wr_byte0 && aw_addr_reg == can_mode_pkg::ADDR_CTL0
                      && w_data_reg[can_mode_pkg::BIT_RECEIVED_FRAME_FLAG]) begin
            ctl0_reg[can_mode_pkg::BIT_RECEIVED_FRAME_FLAG] <= 1'b0;
         end
         // status mirrors, read-only to software
         ctl0_reg[can_mode_pkg::BIT_RECEIVER_ACTIVE] <= !init_mode && link.receiving
                                              && !link.transmitting;
         ctl0_reg[can_mode_pkg::BIT_SYNC]  <= !init_mode && link.synchronized;
         if (init_mode) begin
            ctl0_reg[can_mode_pkg::BIT_STOP_IN_WAIT] <= 1'b0;
            ctl0_reg[can_mode_pkg::BIT_TIME]  <= 1'b0;
         end else if (wr_byte0 && aw_addr_reg == can_mode_pkg::ADDR_CTL0) begin
            ctl0_reg[can_mode_pkg::BIT_STOP_IN_WAIT] <= w_data_reg[can_mode_pkg::BIT_STOP_IN_WAIT];
            ctl0_reg[can_mode_pkg::BIT_TIME]  <= w_data_reg[can_mode_pkg::BIT_TIME];
         end
         // wakeup enable and sleep request stay writable outside init only
         if (wr_byte0 && aw_addr_reg == can_mode_pkg::ADDR_CTL0 && !init_mode) begin
            ctl0_reg[can_mode_pkg::BIT_WAKEUP_ENABLE]  <= w_data_reg[can_mode_pkg::BIT_WAKEUP_ENABLE];
            ctl0_reg[can_mode_pkg::BIT_SLEEP_REQUEST] <= w_data_reg[can_mode_pkg::BIT_SLEEP_REQUEST];
         end else if (wakeup) begin
            ctl0_reg[can_mode_pkg::BIT_SLEEP_REQUEST] <= 1'b0;
         end
         // init request writable in every mode
         if (wr_byte0 && aw_addr_reg == can_mode_pkg::ADDR_CTL0) begin
            ctl0_reg[can_mode_pkg::BIT_INIT_REQUEST] <= w_data_reg[can_mode_pkg::BIT_INIT_REQUEST];
         end
      end
   end

   // ****************************************
   // control one and misc
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         module_enable_reg        <= 1'b0;
         busoff_recovery_mode_reg <= 1'b0;
      end else if (wr_byte0 && aw_addr_reg == can_mode_pkg::ADDR_CTL1 && init_mode) begin
         module_enable_reg        <= w_data_reg[can_mode_pkg::BIT_MODULE_ENABLE];
         busoff_recovery_mode_reg <= w_data_reg[can_mode_pkg::BIT_BUSOFF_RECOVERY_MODE];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         busoff_hold_reg <= 1'b0;
      end else if (link.busoff_enter && busoff_recovery_mode_reg) begin
         busoff_hold_reg <= 1'b1;
      end else if (wr_byte0 && aw_addr_reg == can_mode_pkg::ADDR_MISC
                   && w_data_reg[can_mode_pkg::BIT_BUSOFF_HOLD]) begin
         busoff_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_buffer_select_reg <= '0;
      end else if (wr_byte0 && aw_addr_reg == can_mode_pkg::ADDR_TBSEL) begin
         tx_buffer_select_reg <= w_data_reg[TX_BUFFERS-1:0];
      end
   end

   // ****************************************
   // mode handshakes
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         init_acknowledge_reg <= 1'b0;
      end else begin
         init_acknowledge_reg <= ctl0_reg[can_mode_pkg::BIT_INIT_REQUEST];
      end
   end

   // sleep is granted only on an idle bus, never mid-frame
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sleep_acknowledge_reg <= 1'b0;
         sleep_wakeup_enable_reg        <= 1'b0;
      end else if (!ctl0_reg[can_mode_pkg::BIT_SLEEP_REQUEST] || wakeup) begin
         sleep_acknowledge_reg <= 1'b0;
      end else if (!sleep_acknowledge_reg && link.bus_idle) begin
         sleep_acknowledge_reg <= 1'b1;
         sleep_wakeup_enable_reg        <= ctl0_reg[can_mode_pkg::BIT_WAKEUP_ENABLE];
      end
   end

   // wake-up enable latched at sleep entry, later edits have no effect
   assign wakeup = sleep_mode && sleep_wakeup_enable_reg && link.bus_traffic;

   // bus interface clocks gated off in wait mode when asked
   assign bus_clock_enable = !(wait_mode && ctl0_reg[can_mode_pkg::BIT_STOP_IN_WAIT]);

   // ****************************************
   // bus-off recovery
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst || busoff_recover) begin
         busoff_reg <= 1'b0;
      end else if (link.busoff_enter) begin
         busoff_reg <= 1'b1;
      end
   end

   recessive_counter #(
      .RUN  (can_mode_pkg::RECESSIVE_RUN),
      .RUNS (can_mode_pkg::RECOVERY_RUNS)
   ) u_recessive (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .active    (busoff_reg),
      .tick      (link.bit_tick),
      .recessive (link.recessive_bit),
      .done      (runs_done)
   );

   assign busoff_recover = busoff_reg && runs_done
                           && (!busoff_recovery_mode_reg || !busoff_hold_reg);

   // ****************************************
   // time stamp
   // ****************************************
   bit_timer #(
      .WIDTH (TIMER_WIDTH)
   ) u_timer (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .enable  (ctl0_reg[can_mode_pkg::BIT_TIME]),
      .tick    (link.bit_tick),
      .count   (timer_count)
   );

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stamp_write <= '0;
      end else begin
         stamp_write.we   <= ctl0_reg[can_mode_pkg::BIT_TIME] && link.eof_pulse
                             && !(link.loopback && link.frame_was_rx);
         stamp_write.addr <= 4'hE;
         stamp_write.data <= 16'(timer_count);
      end
   end

   // ****************************************
   // axi4-lite read path
   // ****************************************
   always_comb begin
      rd_value = 32'h00000000;
      rd_ok    = 1'b1;
      unique case (s_axi_araddr)
         can_mode_pkg::ADDR_CTL0:   rd_value[7:0] = ctl0_reg;
         can_mode_pkg::ADDR_CTL1: begin
            rd_value[can_mode_pkg::BIT_MODULE_ENABLE]   = module_enable_reg;
            rd_value[can_mode_pkg::BIT_BUSOFF_RECOVERY_MODE]   = busoff_recovery_mode_reg;
            rd_value[can_mode_pkg::BIT_SLEEP_ACKNOWLEDGE]  = sleep_acknowledge_reg;
            rd_value[can_mode_pkg::BIT_INIT_ACKNOWLEDGE] = init_acknowledge_reg;
         end
         can_mode_pkg::ADDR_MISC:   rd_value[can_mode_pkg::BIT_BUSOFF_HOLD] = busoff_hold_reg;
         can_mode_pkg::ADDR_TXERR: begin
            rd_ok = sleep_mode || init_mode;
            if (rd_ok) begin
               rd_value[7:0] = tx_error_count;
            end
         end
         can_mode_pkg::ADDR_STATUS: begin
            rd_value[can_mode_pkg::BIT_BUSOFF] = busoff_reg;
            rd_value[can_mode_pkg::BIT_SLEEP]  = sleep_mode;
         end
         can_mode_pkg::ADDR_TBSEL:  rd_value[TX_BUFFERS-1:0] = tx_buffer_select_reg;
         can_mode_pkg::ADDR_BUFRD: begin
            // rx gate when nothing selected, else selected tx must be empty
            rd_ok = (tx_buffer_select_reg == '0) ? rx_buffer_full_flag
                    : ((tx_buffer_select_reg & ~tx_buffer_empty_flag) == '0);
            if (rd_ok) begin
               rd_value = buffer_read_data;
            end
         end
         can_mode_pkg::ADDR_TSTAMP: rd_value[TIMER_WIDTH-1:0] = timer_count;
         default:                   rd_ok = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= can_mode_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_value;
         s_axi_rresp  <= rd_ok ? can_mode_pkg::RESP_OKAY : can_mode_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// [verification/can_mode_control_assertions.sv]
`timescale 1ns/1ns
module can_mode_control_assertions (
   input wire logic                       sys_clk,
   input wire logic                       sys_rst,
   input wire logic                       s_axi_arready,
   input wire logic                       s_axi_rvalid,
   input wire logic                       s_axi_rready,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire can_mode_pkg::link_status_t link,
   input wire logic                       wait_mode,
   input wire logic                       bus_clock_enable,
   input wire logic                       busoff_recover,
   input wire logic                       wakeup,
   input wire can_mode_pkg::stamp_write_t stamp_write
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   AST_CLK_RUN: assert property (!wait_mode |-> bus_clock_enable)
      else $error("bus clock stopped outside wait");
   AST_CLK_FALL: assert property ($fell(bus_clock_enable) |-> wait_mode)
      else $error("bus clock fell without wait");
   AST_STAMP_AT: assert property (
      stamp_write.we |-> $past(link.eof_pulse) && stamp_write.addr == 4'hE)
      else $error("stamp write not at frame end or wrong byte");
   AST_NO_LOOP: assert property (
      link.eof_pulse && link.loopback && link.frame_was_rx |=> !stamp_write.we)
      else $error("stamp written in loopback");
   AST_WAKE_CAUSE: assert property (wakeup |-> link.bus_traffic)
      else $error("wakeup without bus traffic");
   AST_BUSOFF_WAIT: assert property (link.busoff_enter |=> !busoff_recover [*8])
      else $error("bus-off recovery too early");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
endmodule

bind can_mode_control can_mode_control_assertions can_mode_control_assertions_i (.*);

// [verification/can_link_model.sv]
`timescale 1ns/1ns
module can_link_model (
   input  wire logic                  sys_clk,
   output can_mode_pkg::link_status_t link
);
   // ****************************************
   // idle bus is recessive, one bit every two clocks
   // ****************************************
   initial begin
      link = '0;
      link.bus_idle = 1'b1;
      link.recessive_bit = 1'b1;
   end

   always @(posedge sys_clk) link.bit_tick <= !link.bit_tick;

   task automatic frame(input logic lb);
      @(posedge sys_clk);
      link.bus_idle <= 1'b0;
      link.receiving <= 1'b1;
      link.recessive_bit <= 1'b0;
      link.loopback <= lb;
      repeat (6) @(posedge sys_clk);
      link.rx_valid_frame <= 1'b1;
      link.eof_pulse <= 1'b1;
      link.frame_was_rx <= 1'b1;
      @(posedge sys_clk);
      {link.rx_valid_frame, link.eof_pulse, link.receiving, link.loopback} <= 4'h0;
      link.bus_idle <= 1'b1;
      link.recessive_bit <= 1'b1;
   endtask

   task automatic busoff();
      @(posedge sys_clk);
      link.busoff_enter <= 1'b1;
      @(posedge sys_clk);
      link.busoff_enter <= 1'b0;
   endtask
endmodule

// [verification/can_mode_control_tb.sv]
`timescale 1ns/1ns
module can_mode_control_tb;
   logic                       sys_clk = 1'b0;
   logic                       sys_rst = 1'b1;
   logic [7:0]                 awaddr = 8'h00;
   logic [7:0]                 araddr = 8'h00;
   logic [7:0]                 txerr = 8'h00;
   logic [31:0]                wdata = 32'h0;
   logic [31:0]                bufd = 32'h0;
   logic                       awvalid = 1'b0;
   logic                       wvalid = 1'b0;
   logic                       arvalid = 1'b0;
   logic                       wait_mode = 1'b0;
   logic                       rx_full = 1'b0;
   logic                       bready = 1'b1;
   logic                       rready = 1'b1;
   logic [2:0]                 tx_empty = 3'h0;
   logic                       awready, wready, bvalid, arready, rvalid;
   logic                       clk_en, recover, wakeup;
   logic [1:0]                 bresp, rresp;
   logic [31:0]                rdata;
   can_mode_pkg::link_status_t link;
   can_mode_pkg::stamp_write_t stamp;
   logic [33:0]                rq[$];
   logic [1:0]                 bq[$];
   int                         miscompares = 0;
   int                         n_compared = 0;
   int                         cyc = 0;
   localparam logic [33:0]     ERR = {can_mode_pkg::RESP_SLVERR, 32'h0};

   always #10 sys_clk = !sys_clk;

   can_mode_control can_mode_control_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .link(link), .tx_error_count(txerr), .tx_buffer_empty_flag(tx_empty),
      .rx_buffer_full_flag(rx_full), .buffer_read_data(bufd), .wait_mode(wait_mode),
      .bus_clock_enable(clk_en), .busoff_recover(recover), .wakeup(wakeup),
      .stamp_write(stamp)
   );
   can_link_model can_link_model_i (.sys_clk(sys_clk), .link(link));

   function automatic logic [33:0] ok(input logic [31:0] d);
      return {can_mode_pkg::RESP_OKAY, d};
   endfunction

   task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ****************************************
   // bus master: ready lines tied high, so every answer is taken at once
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge sys_clk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      @(posedge sys_clk);
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (!rvalid);
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (rvalid) cmp({rresp, rdata}, rq.pop_front());
      if (bvalid) cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (cyc == 10000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      void'($urandom(44130));
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      txerr <= 8'($urandom());
      bufd <= $urandom();
      rd(can_mode_pkg::ADDR_CTL0, ok(32'h01));
      rd(can_mode_pkg::ADDR_CTL1, ok(32'h01));
      wr(can_mode_pkg::ADDR_CTL0, 32'hFF, can_mode_pkg::RESP_OKAY);
      rd(can_mode_pkg::ADDR_CTL0, ok(32'h01));
      rd(can_mode_pkg::ADDR_TXERR, ok({24'h0, txerr}));
      wr(can_mode_pkg::ADDR_TXERR, 32'h0, can_mode_pkg::RESP_SLVERR);
      rd(8'h40, ERR);
      $display("init test done");
      wr(can_mode_pkg::ADDR_CTL1, 32'h80, can_mode_pkg::RESP_OKAY);
      wr(can_mode_pkg::ADDR_CTL0, 32'h00, can_mode_pkg::RESP_OKAY);
      rd(can_mode_pkg::ADDR_CTL1, ok(32'h80));
      rd(can_mode_pkg::ADDR_TXERR, ERR);
      rd(can_mode_pkg::ADDR_BUFRD, ERR);
      rx_full <= 1'b1;
      rd(can_mode_pkg::ADDR_BUFRD, ok(bufd));
      $display("run test done");
      can_link_model_i.link.synchronized <= 1'b1;
      can_link_model_i.frame(1'b0);
      rd(can_mode_pkg::ADDR_CTL0, ok(32'h90));
      wr(can_mode_pkg::ADDR_CTL0, 32'h00, can_mode_pkg::RESP_OKAY);
      rd(can_mode_pkg::ADDR_CTL0, ok(32'h90));
      wr(can_mode_pkg::ADDR_CTL0, 32'h08, can_mode_pkg::RESP_OKAY);
      can_link_model_i.frame(1'b0);
      @(negedge sys_clk);
      cmp({29'h0, stamp.we, stamp.addr}, {29'h0, 1'b1, 4'hE});
      can_link_model_i.frame(1'b1);
      @(negedge sys_clk);
      cmp({33'h0, stamp.we}, 34'h0);
      wr(can_mode_pkg::ADDR_CTL0, 32'h80, can_mode_pkg::RESP_OKAY);
      rd(can_mode_pkg::ADDR_CTL0, ok(32'h10));
      rd(can_mode_pkg::ADDR_TSTAMP, ok(32'h0));
      $display("frame test done");
      wr(can_mode_pkg::ADDR_CTL0, 32'h20, can_mode_pkg::RESP_OKAY);
      wait_mode <= 1'b1;
      repeat (2) @(posedge sys_clk);
      cmp({33'h0, clk_en}, 34'h0);
      wait_mode <= 1'b0;
      wr(can_mode_pkg::ADDR_CTL0, 32'h04, can_mode_pkg::RESP_OKAY);
      wait_mode <= 1'b1;
      repeat (2) @(posedge sys_clk);
      cmp({33'h0, clk_en}, 34'h1);
      wait_mode <= 1'b0;
      $display("wait test done");
      wr(can_mode_pkg::ADDR_CTL0, 32'h06, can_mode_pkg::RESP_OKAY);
      rd(can_mode_pkg::ADDR_CTL1, ok(32'h82));
      rd(can_mode_pkg::ADDR_TXERR, ok({24'h0, txerr}));
      can_link_model_i.link.bus_traffic <= 1'b1;
      @(posedge sys_clk);
      cmp({33'h0, wakeup}, 34'h1);
      can_link_model_i.link.bus_traffic <= 1'b0;
      rd(can_mode_pkg::ADDR_CTL0, ok(32'h14));
      wr(can_mode_pkg::ADDR_CTL0, 32'h02, can_mode_pkg::RESP_OKAY);
      rd(can_mode_pkg::ADDR_CTL1, ok(32'h82));
      can_link_model_i.link.bus_traffic <= 1'b1;
      @(posedge sys_clk);
      cmp({33'h0, wakeup}, 34'h0);
      can_link_model_i.link.bus_traffic <= 1'b0;
      wr(can_mode_pkg::ADDR_CTL0, 32'h00, can_mode_pkg::RESP_OKAY);
      $display("sleep test done");
      can_link_model_i.busoff();
      repeat (2800) @(posedge sys_clk);
      cmp({33'h0, recover}, 34'h0);
      for (int i = 0; i < 100 && recover !== 1'b1; i++) @(posedge sys_clk);
      cmp({33'h0, recover}, 34'h1);
      $display("bus-off test done");
      end_of_test();
   end
endmodule
